// ==== core/mssr_monitor_sec.v ====
`timescale 1ns/10ps
`include "mssr_regs.vh"

module mssr_monitor_sec
(
    // Clock and reset
    input  wire        clk,
    input  wire        srst,
    input  wire        por_rst,
    // Monitor entry
    input  wire        mon_entry,
    // Received bytes from the monitor serial pin
    input  wire        rx_valid,
    input  wire [7:0]  rx_data,
    // Transmit requests toward the monitor serial pin
    output reg         tx_break,
    output reg         tx_valid,
    output reg  [7:0]  tx_data,
    // CPU sequencer
    output reg         cpu_op_valid,
    output reg  [1:0]  cpu_op,
    input  wire        cpu_op_ack,
    input  wire [15:0] stack_ptr,
    // Flash read path
    input  wire        flash_rd_req,
    input  wire [7:0]  flash_rd_raw,
    output reg         flash_rd_valid,
    output reg  [7:0]  flash_rd_data,
    // Flash fetch guard
    input  wire        flash_fetch,
    output reg         illegal_addr_rst,
    // Security store programming
    input  wire        sec_prog_we,
    input  wire [2:0]  sec_prog_idx,
    input  wire [7:0]  sec_prog_data,
    input  wire        mass_erase,
    // Status byte write into RAM
    output reg         ram_wr_en,
    output reg  [15:0] ram_wr_addr,
    output reg  [7:0]  ram_wr_data,
    // Security state
    output reg         unlocked,
    output reg         monitor_ready
);

    // ======================================================================
    // States.
    localparam [8:0] ST_IDLE = 9'h001;
    localparam [8:0] ST_SEC  = 9'h002;
    localparam [8:0] ST_TRAP = 9'h004;
    localparam [8:0] ST_PUSH = 9'h008;
    localparam [8:0] ST_BRK  = 9'h010;
    localparam [8:0] ST_RDY  = 9'h020;
    localparam [8:0] ST_PULL = 9'h040;
    localparam [8:0] ST_RETN = 9'h080;
    localparam [8:0] ST_SPL  = 9'h100;

    reg  [8:0]  state_r;
    reg  [8:0]  state_nxt;
    reg  [3:0]  cnt_r;
    reg  [3:0]  cnt_nxt;
    reg         miss_r;
    reg         miss_nxt;
    reg         code_done_r;
    reg         code_done_nxt;
    reg         unlock_nxt;
    reg  [7:0]  sp_lo_r;
    reg  [7:0]  sp_lo_nxt;
    reg         stat_wr_nxt;
    reg  [7:0]  stat_data_nxt;
    reg         brk_nxt;
    reg         txv_nxt;
    reg  [7:0]  txd_nxt;
    reg         opv_nxt;
    reg  [1:0]  op_nxt;
    wire [7:0]  sec_byte;
    wire        byte_ok;
    wire [15:0] sp_query;

    assign byte_ok  = (rx_data == sec_byte);
    assign sp_query = stack_ptr + `MSSR_SP_QUERY_OFS;

    // ======================================================================
    // Security byte storage.
    mssr_sec_store u_store
    (
        .clk        (clk),
        .srst       (srst),
        .prog_we    (sec_prog_we),
        .prog_idx   (sec_prog_idx),
        .prog_data  (sec_prog_data),
        .mass_erase (mass_erase),
        .rd_idx     (cnt_r[2:0]),
        .rd_data    (sec_byte)
    );

    // ======================================================================
    // Next state.
    always @*
    begin
        state_nxt     = state_r;
        cnt_nxt       = cnt_r;
        miss_nxt      = miss_r;
        code_done_nxt = code_done_r;
        unlock_nxt    = unlocked;
        sp_lo_nxt     = sp_lo_r;
        stat_wr_nxt   = 1'b0;
        stat_data_nxt = `MSSR_STAT_CLR;
        brk_nxt       = 1'b0;
        txv_nxt       = 1'b0;
        txd_nxt       = tx_data;
        opv_nxt       = cpu_op_valid;
        op_nxt        = cpu_op;
        case (state_r)
            ST_IDLE:
            begin
                if (mon_entry)
                begin
                    cnt_nxt  = 4'h0;
                    miss_nxt = 1'b0;
                    if (code_done_r)
                    begin
                        // Code already given since power-on.
                        state_nxt = ST_TRAP;
                        opv_nxt   = 1'b1;
                        op_nxt    = `MSSR_OP_TRAP;
                    end
                    else
                    begin
                        state_nxt = ST_SEC;
                    end
                end
            end
            ST_SEC:
            begin
                if (rx_valid)
                begin
                    miss_nxt = miss_r | ~byte_ok;
                    cnt_nxt  = cnt_r + 4'h1;
                    if (cnt_r[2:0] == `MSSR_SEC_LAST)
                    begin
                        code_done_nxt = 1'b1;
                        unlock_nxt    = ~(miss_r | ~byte_ok);
                        stat_wr_nxt   = 1'b1;
                        stat_data_nxt = (miss_r | ~byte_ok) ?
                                        `MSSR_STAT_CLR :
                                        `MSSR_STAT_SET;
                        state_nxt     = ST_TRAP;
                        opv_nxt       = 1'b1;
                        op_nxt        = `MSSR_OP_TRAP;
                    end
                end
            end
            ST_TRAP:
            begin
                if (cpu_op_ack)
                begin
                    state_nxt = ST_PUSH;
                    op_nxt    = `MSSR_OP_PUSH;
                end
            end
            ST_PUSH:
            begin
                if (cpu_op_ack)
                begin
                    opv_nxt   = 1'b0;
                    state_nxt = ST_BRK;
                end
            end
            ST_BRK:
            begin
                // Break follows the push op, also on an entry that skips the security sequence.
                brk_nxt   = 1'b1;
                state_nxt = ST_RDY;
            end
            ST_RDY:
            begin
                if (rx_valid)
                begin
                    if (rx_data == `MSSR_CMD_RUN)
                    begin
                        // The run command answers with no data.
                        state_nxt = ST_PULL;
                        opv_nxt   = 1'b1;
                        op_nxt    = `MSSR_OP_PULL;
                    end
                    else if (rx_data == `MSSR_CMD_SPQ)
                    begin
                        txv_nxt   = 1'b1;
                        txd_nxt   = sp_query[15:8];
                        sp_lo_nxt = sp_query[7:0];
                        state_nxt = ST_SPL;
                    end
                end
            end
            ST_SPL:
            begin
                // High byte first, then low byte.
                txv_nxt   = 1'b1;
                txd_nxt   = sp_lo_r;
                state_nxt = ST_RDY;
            end
            ST_PULL:
            begin
                if (cpu_op_ack)
                begin
                    state_nxt = ST_RETN;
                    op_nxt    = `MSSR_OP_RETN;
                end
            end
            ST_RETN:
            begin
                if (cpu_op_ack)
                begin
                    // The user program now runs from the stacked state.
                    opv_nxt   = 1'b0;
                    state_nxt = ST_IDLE;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
                opv_nxt   = 1'b0;
            end
        endcase
    end

    // ======================================================================
    // State registers.
    always @(posedge clk)
    begin
        if (srst)
        begin
            state_r       <= ST_IDLE;
            cnt_r         <= 4'h0;
            miss_r        <= 1'b0;
            sp_lo_r       <= 8'h00;
            tx_break      <= 1'b0;
            tx_valid      <= 1'b0;
            tx_data       <= 8'h00;
            cpu_op_valid  <= 1'b0;
            cpu_op        <= `MSSR_OP_TRAP;
            ram_wr_en     <= 1'b0;
            ram_wr_addr   <= `MSSR_STAT_ADDR;
            ram_wr_data   <= `MSSR_STAT_CLR;
            monitor_ready <= 1'b0;
            // Only a power-on reset forgets the security outcome.
            if (por_rst)
            begin
                unlocked    <= 1'b0;
                code_done_r <= 1'b0;
            end
        end
        else
        begin
            state_r       <= state_nxt;
            cnt_r         <= cnt_nxt;
            miss_r        <= miss_nxt;
            code_done_r   <= code_done_nxt;
            unlocked      <= unlock_nxt;
            sp_lo_r       <= sp_lo_nxt;
            tx_break      <= brk_nxt;
            tx_valid      <= txv_nxt;
            tx_data       <= txd_nxt;
            cpu_op_valid  <= opv_nxt;
            cpu_op        <= op_nxt;
            ram_wr_en     <= stat_wr_nxt;
            ram_wr_addr   <= `MSSR_STAT_ADDR;
            ram_wr_data   <= stat_data_nxt;
            monitor_ready <= (state_nxt == ST_RDY);
        end
    end

    // ======================================================================
    // Flash access guard.
    // The read answer is registered so it never glitches on a lock change.
    always @(posedge clk)
    begin
        if (srst)
        begin
            flash_rd_valid   <= 1'b0;
            flash_rd_data    <= 8'h00;
            illegal_addr_rst <= 1'b0;
        end
        else
        begin
            flash_rd_valid   <= flash_rd_req;
            flash_rd_data    <= unlocked ? flash_rd_raw :
                                `MSSR_INVALID_DATA;
            illegal_addr_rst <= flash_fetch & ~unlocked;
        end
    end

endmodule

// ==== core/mssr_regs.vh ====
`ifndef MSSR_REGS_VH
`define MSSR_REGS_VH

// ==========================================================================
// Monitor commands.
`define MSSR_CMD_RUN        8'h28
`define MSSR_CMD_SPQ        8'h0C

// ==========================================================================
// Security code.
`define MSSR_SEC_COUNT      4'h8
`define MSSR_SEC_LAST       3'h7
`define MSSR_SEC_BLANK      8'hFF

// ==========================================================================
// Status byte in RAM that tells the host whether unlocking succeeded.
`define MSSR_STAT_ADDR      16'h0080
`define MSSR_STAT_BIT       6
`define MSSR_STAT_SET       8'h40
`define MSSR_STAT_CLR       8'h00

// ==========================================================================
// Value returned for flash reads while secured.
`define MSSR_INVALID_DATA   8'h00

// ==========================================================================
// Operation codes handed to the CPU sequencer.
`define MSSR_OP_TRAP        2'h0
`define MSSR_OP_PUSH        2'h1
`define MSSR_OP_PULL        2'h2
`define MSSR_OP_RETN        2'h3

// ==========================================================================
// Stack layout relative to the stack pointer.
`define MSSR_SP_QUERY_OFS   16'h0001
`define MSSR_SP_PCH_OFS     16'h0005
`define MSSR_SP_PCL_OFS     16'h0006

`endif

// ==== core/mssr_sec_store.v ====
`timescale 1ns/10ps
`include "mssr_regs.vh"

// ==========================================================================
// Eight security bytes at the top of flash, with mass erase.
module mssr_sec_store
(
    // Clock and reset
    input  wire       clk,
    input  wire       srst,
    // Programming port
    input  wire       prog_we,
    input  wire [2:0] prog_idx,
    input  wire [7:0] prog_data,
    input  wire       mass_erase,
    // Read port
    input  wire [2:0] rd_idx,
    output wire [7:0] rd_data
);

    reg [7:0] mem_r [0:7];

    genvar g;

    // ======================================================================
    // Storage.
    // Flash keeps its contents across resets, so srst is not used here.
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_byte
            always @(posedge clk)
            begin
                if (mass_erase)
                begin
                    mem_r[g] <= `MSSR_SEC_BLANK;
                end
                else if (prog_we && prog_idx == g)
                begin
                    mem_r[g] <= prog_data;
                end
            end
        end
    endgenerate

    assign rd_data = mem_r[rd_idx];

endmodule

// ==== verification/mssr_chk_assertions.sv ====
`timescale 1ns/10ps
// ========
// Checker on the monitor security ports.
module mssr_chk
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // CPU sequencer and host link
    input wire logic        cpu_op_valid,
    input wire logic [1:0]  cpu_op,
    input wire logic        cpu_op_ack,
    input wire logic        tx_break,
    input wire logic        monitor_ready,
    // Flash and status
    input wire logic        flash_rd_req,
    input wire logic [7:0]  flash_rd_raw,
    input wire logic        flash_rd_valid,
    input wire logic [7:0]  flash_rd_data,
    input wire logic        flash_fetch,
    input wire logic        illegal_addr_rst,
    input wire logic        ram_wr_en,
    input wire logic [15:0] ram_wr_addr,
    input wire logic [7:0]  ram_wr_data,
    input wire logic        unlocked
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // Ready may only follow a break given since the last trap op.
    logic brk_seen_r;
    always @(posedge clk)
    begin
        if (srst || (cpu_op_valid && cpu_op == 2'h0))
            brk_seen_r <= 1'b0;
        else if (tx_break)
            brk_seen_r <= 1'b1;
    end
    sequence s_ack(logic [1:0] o);
        cpu_op_valid && cpu_op == o && cpu_op_ack;
    endsequence
    chk_entry_push: assert property (s_ack(2'h0) |=>
        cpu_op_valid && cpu_op == 2'h1) else $error("push missing");
    chk_run_return: assert property (s_ack(2'h2) |=>
        cpu_op_valid && cpu_op == 2'h3) else $error("return missing");
    chk_op_hold: assert property (cpu_op_valid && !cpu_op_ack |=>
        cpu_op_valid && $stable(cpu_op)) else $error("op dropped");
    chk_break_after: assert property (s_ack(2'h1) |->
        ##[1:2] tx_break) else $error("break missing");
    chk_ready_late: assert property (monitor_ready |->
        tx_break || brk_seen_r) else $error("ready before break");
    chk_rd_locked: assert property (flash_rd_req && !unlocked |=>
        flash_rd_valid && flash_rd_data == 8'h00) else $error("rd leak");
    chk_rd_open: assert property (flash_rd_req && unlocked |=>
        flash_rd_valid && flash_rd_data == $past(flash_rd_raw))
        else $error("rd data wrong");
    chk_fetch_trap: assert property (flash_fetch && !unlocked |=>
        illegal_addr_rst) else $error("no illegal reset");
    chk_stat_write: assert property (ram_wr_en |->
        ram_wr_addr == 16'h0080 && ram_wr_data == (unlocked ? 8'h40 : 8'h00))
        else $error("status byte wrong");
endmodule

// ==== verification/mssr_host.sv ====
`timescale 1ns/10ps
// ========
// Host model driving the monitor serial byte stream.
module mssr_host
(
    // Clock and device side
    input wire logic  clk,
    input wire logic  tx_break,
    // Byte stream into the device
    output logic       rx_valid,
    output logic [7:0] rx_data
);
    // Idle cycles between bytes, so a slow host can be modelled.
    int   gap = 1;
    logic ready = 1'b0;
    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end
    always @(posedge clk)
    begin
        if (tx_break)
            ready <= 1'b1;
    end
    task send(input logic [7:0] b);
        @(negedge clk);
        rx_valid = 1'b1;
        rx_data = b;
        @(negedge clk);
        rx_valid = 1'b0;
        // The released line must not keep showing the old byte.
        rx_data = ~b;
        repeat (gap) @(negedge clk);
    endtask
    task send_code(input logic [63:0] c, input int n);
        for (int k = 0; k < n; k++)
            send(c[63 - 8 * k -: 8]);
    endtask
    task send_cmd(input logic [7:0] c);
        if (ready)
            send(c);
    endtask
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/10ps
// ========
// Bench for the monitor security block.
module tb;
    logic        clk, srst, por_rst, mon_entry, rx_valid, cpu_op_ack;
    logic        flash_rd_req, flash_fetch, sec_prog_we, mass_erase;
    logic        tx_break, tx_valid, cpu_op_valid, flash_rd_valid;
    logic        illegal_addr_rst, ram_wr_en, unlocked, monitor_ready;
    logic [1:0]  cpu_op;
    logic [2:0]  sec_prog_idx;
    logic [7:0]  rx_data, tx_data, flash_rd_raw, flash_rd_data;
    logic [7:0]  sec_prog_data, ram_wr_data, ram_d;
    logic [15:0] stack_ptr, ram_wr_addr;
    logic [7:0]  txq[$];
    int          fails = 0;
    int          comparisons = 0;
    int          brk_n = 0;
    typedef struct { logic [63:0] code; logic exp; } mssr_row_t;
    localparam logic [63:0] KEY = 64'h3C5A96E10F7B24D8;
    mssr_row_t   rows [3] = '{'{KEY, 1'b1},
        '{KEY ^ 64'h0100000000000000, 1'b0}, '{KEY ^ 64'h1, 1'b0}};
    mssr_monitor_sec u_mssr_monitor_sec (.clk(clk), .srst(srst),
        .por_rst(por_rst), .mon_entry(mon_entry), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_break(tx_break), .tx_valid(tx_valid),
        .tx_data(tx_data), .cpu_op_valid(cpu_op_valid), .cpu_op(cpu_op),
        .cpu_op_ack(cpu_op_ack), .stack_ptr(stack_ptr),
        .flash_rd_req(flash_rd_req), .flash_rd_raw(flash_rd_raw),
        .flash_rd_valid(flash_rd_valid), .flash_rd_data(flash_rd_data),
        .flash_fetch(flash_fetch), .illegal_addr_rst(illegal_addr_rst),
        .sec_prog_we(sec_prog_we), .sec_prog_idx(sec_prog_idx),
        .sec_prog_data(sec_prog_data), .mass_erase(mass_erase),
        .ram_wr_en(ram_wr_en), .ram_wr_addr(ram_wr_addr),
        .ram_wr_data(ram_wr_data), .unlocked(unlocked),
        .monitor_ready(monitor_ready));
    mssr_host u_mssr_host (.clk(clk), .tx_break(tx_break),
        .rx_valid(rx_valid), .rx_data(rx_data));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (tx_break) brk_n++;
        if (tx_valid) txq.push_back(tx_data);
        if (ram_wr_en) ram_d <= ram_wr_data;
    end
    task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        comparisons++;
        if (s !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task end_sim;
        $display("Checks %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Only a power-on reset may clear the unlock.
    task do_rst(input logic por);
        @(negedge clk);
        srst = 1'b1;
        por_rst = por;
        repeat (8) @(negedge clk);
        srst = 1'b0;
        por_rst = 1'b0;
        u_mssr_host.ready = 1'b0;
        txq.delete();
    endtask
    task automatic op_step(input logic [1:0] op, input int dly);
        int t;
        t = 0;
        while (cpu_op_valid !== 1'b1 && t < 50)
        begin
            @(negedge clk);
            t++;
        end
        chk("op_valid", 16'h1, 16'(cpu_op_valid));
        chk("cpu_op", 16'(op), 16'(cpu_op));
        repeat (dly) @(negedge clk);
        cpu_op_ack = 1'b1;
        @(negedge clk);
        cpu_op_ack = 1'b0;
    endtask
    task automatic enter(input logic [63:0] code, input logic bytes);
        int b;
        b = brk_n;
        @(negedge clk);
        mon_entry = 1'b1;
        @(negedge clk);
        mon_entry = 1'b0;
        if (bytes)
        begin
            u_mssr_host.send_code(code, 7);
            repeat (4) @(negedge clk);
            chk("early_op", 16'h0, 16'(cpu_op_valid));
            chk("early_break", 16'(b), 16'(brk_n));
            u_mssr_host.send(code[7:0]);
        end
        op_step(2'h0, 0);
        op_step(2'h1, 3);
        repeat (4) @(negedge clk);
        chk("break", 16'(b + 1), 16'(brk_n));
        chk("ready", 16'h1, 16'(monitor_ready));
    endtask
    task probe(input logic exp);
        @(negedge clk);
        flash_rd_req = 1'b1;
        flash_rd_raw = 8'hA5;
        flash_fetch = 1'b1;
        @(negedge clk);
        flash_rd_req = 1'b0;
        flash_rd_raw = 8'h5A;
        flash_fetch = 1'b0;
        chk("rd_valid", 16'h1, 16'(flash_rd_valid));
        chk("rd_data", exp ? 16'hA5 : 16'h0, 16'(flash_rd_data));
        chk("illegal", 16'(!exp), 16'(illegal_addr_rst));
    endtask
    initial
    begin
        {srst, por_rst, stack_ptr} = {2'h3, 16'h12FF};
        {mon_entry, cpu_op_ack, flash_rd_req, flash_fetch} = 4'h0;
        {sec_prog_we, sec_prog_idx, sec_prog_data} = 12'h0;
        {mass_erase, flash_rd_raw, ram_d} = 17'h0;
        repeat (8) @(negedge clk);
        srst = 1'b0;
        por_rst = 1'b0;
        for (int k = 0; k < 8; k++)
        begin
            @(negedge clk);
            sec_prog_we = 1'b1;
            sec_prog_idx = 3'(k);
            sec_prog_data = KEY[63 - 8 * k -: 8];
        end
        @(negedge clk);
        sec_prog_we = 1'b0;
        foreach (rows[i])
        begin
            u_mssr_host.gap = 1 + 3 * i;
            do_rst(1'b1);
            enter(rows[i].code, 1'b1);
            chk("unlocked", 16'(rows[i].exp), 16'(unlocked));
            chk("status", rows[i].exp ? 16'h40 : 16'h0, 16'(ram_d));
            probe(rows[i].exp);
            u_mssr_host.send_cmd(8'h0C);
            repeat (4) @(negedge clk);
            chk("sp_count", 16'h2, 16'(txq.size()));
            chk("sp_hi", 16'h13, 16'(txq[0]));
            chk("sp_lo", 16'h0, 16'(txq[1]));
            txq.delete();
            u_mssr_host.send_cmd(8'h28);
            op_step(2'h2, 0);
            op_step(2'h3, 2);
            repeat (3) @(negedge clk);
            chk("run_ready", 16'h0, 16'(monitor_ready));
            chk("run_tx", 16'h0, 16'(txq.size()));
            $display("Test row %0d done", i);
        end
        do_rst(1'b1);
        enter(KEY, 1'b1);
        do_rst(1'b0);
        chk("kept", 16'h1, 16'(unlocked));
        enter(KEY, 1'b0);
        probe(1'b1);
        $display("Test warm reset done");
        @(negedge clk);
        mass_erase = 1'b1;
        @(negedge clk);
        mass_erase = 1'b0;
        do_rst(1'b1);
        enter({8{8'hFF}}, 1'b1);
        chk("blank_unlock", 16'h1, 16'(unlocked));
        $display("Test mass erase done");
        end_sim;
    end
    // Whole run needs well under a thousand cycles; this 20000-cycle bound is generous.
    initial
    begin
        #100000;
        fails++;
        $display("Error watchdog expected finish seen timeout");
        end_sim;
    end
endmodule
bind mssr_monitor_sec mssr_chk u_mssr_chk (.clk(clk), .srst(srst),
    .cpu_op_valid(cpu_op_valid), .cpu_op(cpu_op), .cpu_op_ack(cpu_op_ack),
    .tx_break(tx_break), .monitor_ready(monitor_ready),
    .flash_rd_req(flash_rd_req), .flash_rd_raw(flash_rd_raw),
    .flash_rd_valid(flash_rd_valid), .flash_rd_data(flash_rd_data),
    .flash_fetch(flash_fetch), .illegal_addr_rst(illegal_addr_rst),
    .ram_wr_en(ram_wr_en), .ram_wr_addr(ram_wr_addr),
    .ram_wr_data(ram_wr_data), .unlocked(unlocked));
